/* File: rtl/mbre_engine.sv */
// Purpose: serial request engine, master issues, slave answers
// Assumes: byte-level serial channel outside; one scan = one clock
// Notes: character framing itself is outside; data width reported only
`timescale 1ns/1ps
`default_nettype none
module mbre_engine #(
   parameter int TIMEOUT_CYC = mbre_pkg::TIMEOUT_CYC,
   parameter int ACK_WAIT_CYC = mbre_pkg::ACK_WAIT_CYC
) (
   input wire logic ref_clk_in,          // clock
   input wire logic nrst_in,             // async reset, active low
   input wire logic master_mode_in,      // 1 master, 0 slave
   input wire logic rtu_mode_in,         // 1 rtu, 0 ascii
   input wire logic params_ok_in,        // port parameters valid
   input wire logic legacy_form_in,      // legacy request form used
   input wire logic [1:0] channel_select_in, // requested channel
   input wire logic [4:0] own_station_in,    // own station number
   input wire logic exec_in,             // execution condition
   input wire logic [15:0] station_function_operand_in, // station:function
   input wire logic [15:0] start_address_operand_in,    // item number
   input wire logic [15:0] count_in,     // number of items
   input wire logic rx_vld_in,           // received byte valid
   input wire logic [7:0] rx_byte_in,    // received byte
   input wire logic rx_end_in,           // received frame end
   input wire logic tx_rdy_in,           // transmitter accepts byte
   input wire logic [15:0] local_bits_in, // slave local bit image
   output logic tx_vld_out,              // transmit byte valid
   output logic [7:0] tx_byte_out,       // transmit byte
   output logic tx_end_out,              // last byte of frame
   output logic [1:0] channel_out,       // channel in use
   output logic [3:0] data_bits_out,     // character data bits
   output logic [15:0] status_word_operand_out, // code:flags
   output logic rd_vld_out,              // read data byte pulse
   output logic [7:0] rd_byte_out        // read data byte
);
   ////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_SEND = 3'b001, ST_WAIT = 3'b010,
      ST_RECV = 3'b011, ST_HOLD = 3'b100, ST_SANS = 3'b101
   } mbre_state_e;

   function automatic logic [15:0] status_of(input logic ok, input logic [7:0] code);
      logic [15:0] s;
      s = 16'h0000;
      if (ok) s[mbre_pkg::DONE_BIT] = 1'b1;
      else begin
         s[mbre_pkg::ERR_BIT] = 1'b1;
         s[mbre_pkg::CODE_LSB +: 8] = code;
      end
      return s;
   endfunction

   function automatic logic [15:0] byte_count(input logic [7:0] fn, input logic [15:0] n);
      // widened sum for bit reads, saturation for word reads, so huge counts never wrap below the limit
      if (fn == mbre_pkg::FN_READ_COILS || fn == mbre_pkg::FN_READ_INPUTS)
         byte_count = 16'(({1'b0, n} + 17'h00007) >> 3);
      else if (n[15]) byte_count = 16'hFFFF;
      else byte_count = 16'(n << 1);
   endfunction

   initial begin
      if (TIMEOUT_CYC < 1 || ACK_WAIT_CYC < 1) $error("bad wait counts");
   end

   ////////////////////////////////////////////////////////////////////
   mbre_state_e st_reg, st_next;
   logic exec_reg, exec_next;
   logic [7:0] frm_reg [0:5];
   logic [7:0] frm_next [0:5];
   logic [2:0] idx_reg, idx_next;
   logic [31:0] tmr_reg, tmr_next;
   logic [15:0] stat_reg, stat_next;
   logic [15:0] nbyte_reg, nbyte_next;
   logic [3:0] rxi_reg, rxi_next;
   logic exc_reg, exc_next;
   logic [1:0] ch_reg, ch_next;
   logic [3:0] db_reg, db_next;
   logic tv_reg, tv_next, te_reg, te_next;
   logic [7:0] tb_reg, tb_next;
   logic rv_reg, rv_next;
   logic [7:0] rb_reg, rb_next;
   logic pk_clr, pk_vld, pk_bit, pk_flush, pk_bv;
   logic [7:0] pk_byte;
   logic [4:0] pk_cnt_reg, pk_cnt_next;
   logic [7:0] sa_reg, sa_next;
   logic [7:0] tgt_fn;
   logic [4:0] tgt_st;
   logic [15:0] bytes_req;
   logic rise;
   integer i;

   assign tgt_st = station_function_operand_in[12:8];
   assign tgt_fn = station_function_operand_in[7:0];
   assign bytes_req = byte_count(tgt_fn, count_in);
   assign rise = exec_in && !exec_reg;

   mbre_bit_packer u_pack (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .clr_in(pk_clr),
      .bit_vld_in(pk_vld),
      .bit_in(pk_bit),
      .flush_in(pk_flush),
      .byte_vld_out(pk_bv),
      .byte_out(pk_byte)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      exec_next = exec_in;
      for (i = 0; i < 6; i++) frm_next[i] = frm_reg[i];
      idx_next = idx_reg;
      tmr_next = tmr_reg;
      stat_next = 16'h0000;
      nbyte_next = nbyte_reg;
      rxi_next = rxi_reg;
      exc_next = exc_reg;
      tv_next = 1'b0;
      te_next = 1'b0;
      tb_next = tb_reg;
      rv_next = 1'b0;
      rb_next = rb_reg;
      pk_clr = 1'b0;
      pk_vld = 1'b0;
      pk_bit = 1'b0;
      pk_flush = 1'b0;
      pk_cnt_next = pk_cnt_reg;
      sa_next = sa_reg;
      ch_next = legacy_form_in ? mbre_pkg::CH_LEGACY : channel_select_in;
      db_next = rtu_mode_in ? mbre_pkg::DBITS_RTU : mbre_pkg::DBITS_ASCII;
      case (st_reg)
         ST_IDLE: begin
            if (master_mode_in && rise) begin
               if (!params_ok_in) stat_next = status_of(1'b0, mbre_pkg::ERR_PARAM);
               else if (tgt_st == own_station_in)
                  stat_next = status_of(1'b0, mbre_pkg::ERR_STATION);
               else if (count_in == 16'h0000 || bytes_req > 16'(mbre_pkg::MAX_BYTES))
                  stat_next = status_of(1'b0, mbre_pkg::ERR_NUMBER);
               else begin
                  frm_next[0] = {3'h0, tgt_st};
                  frm_next[1] = tgt_fn;
                  frm_next[2] = 8'((start_address_operand_in - 16'h0001) >> 8);
                  frm_next[3] = 8'(start_address_operand_in - 16'h0001);
                  frm_next[4] = count_in[15:8];
                  frm_next[5] = count_in[7:0];
                  idx_next = 3'h0;
                  st_next = ST_SEND;
               end
            end else if (!master_mode_in && rx_vld_in) begin
               frm_next[0] = rx_byte_in;
               rxi_next = 4'h1;
               st_next = ST_RECV;
            end
         end
         ST_SEND: begin
            if (tx_rdy_in && !tv_reg) begin
               tv_next = 1'b1;
               tb_next = frm_reg[idx_reg];
               te_next = (idx_reg == 3'h5);
               idx_next = idx_reg + 3'h1;
               if (idx_reg == 3'h5) begin
                  tmr_next = 32'h0;
                  rxi_next = 4'h0;
                  st_next = master_mode_in ? ST_WAIT : ST_IDLE;
                  if (!master_mode_in) stat_next = status_of(1'b1, 8'h00);
               end
            end
         end
         ST_WAIT: begin
            tmr_next = tmr_reg + 32'h1;
            if (rx_vld_in) begin
               // header: station, function, then exception code or byte count
               if (rxi_reg == 4'h1) exc_next = rx_byte_in[7];
               if (rxi_reg == 4'h2 && exc_reg) begin
                  if (rx_byte_in == mbre_pkg::ERR_ACK) begin
                     stat_next = status_of(1'b0, rx_byte_in);
                     tmr_next = 32'h0;
                     st_next = ST_HOLD;
                  end else begin
                     stat_next = status_of(1'b0, rx_byte_in);
                     st_next = ST_IDLE;
                  end
               end
               if (rxi_reg >= 4'h3 && !exc_reg) rv_next = 1'b1;
               rb_next = rx_byte_in;
               if (rxi_reg != 4'hF) rxi_next = rxi_reg + 4'h1;
            end
            if (rx_end_in && !exc_reg && rxi_reg >= 4'h3) begin
               stat_next = status_of(1'b1, 8'h00);
               st_next = ST_IDLE;
            end else if (tmr_reg >= 32'(TIMEOUT_CYC - 1) && st_next == ST_WAIT) begin
               stat_next = status_of(1'b0, mbre_pkg::ERR_TIMEOUT);
               st_next = ST_IDLE;
            end
         end
         ST_HOLD: begin
            tmr_next = tmr_reg + 32'h1;
            if (tmr_reg >= 32'(ACK_WAIT_CYC - 1)) st_next = ST_IDLE;
         end
         ST_RECV: begin
            if (rx_vld_in && rxi_reg < 4'h6) begin
               frm_next[rxi_reg[2:0]] = rx_byte_in;
               rxi_next = rxi_reg + 4'h1;
            end
            if (rx_end_in) begin
               if (rxi_reg == 4'h6 && frm_reg[0][4:0] == own_station_in &&
                   frm_reg[0] != {3'h0, mbre_pkg::BCAST_STATION}) begin
                  // bit reads answered from local image
                  if (frm_reg[1] == mbre_pkg::FN_READ_COILS ||
                      frm_reg[1] == mbre_pkg::FN_READ_INPUTS) begin
                     pk_clr = 1'b1;
                     pk_cnt_next = 5'h0;
                     // start item kept aside: frame bytes get overwritten by data
                     sa_next = frm_reg[3];
                     st_next = ST_SANS;
                  end else begin
                     frm_next[1] = frm_reg[1] | mbre_pkg::EXC_FLAG;
                     frm_next[2] = mbre_pkg::ERR_ILL_FUNC;
                     idx_next = 3'h0;
                     frm_next[3] = 8'h00;
                     frm_next[4] = 8'h00;
                     frm_next[5] = 8'h00;
                     st_next = ST_SEND;
                  end
               end else st_next = ST_IDLE;
            end
         end
         ST_SANS: begin
            if (pk_cnt_reg < 5'd16 && 16'(pk_cnt_reg) < frm_reg[5]) begin
               pk_vld = 1'b1;
               pk_bit = local_bits_in[4'(sa_reg + 8'(pk_cnt_reg))];
               pk_cnt_next = pk_cnt_reg + 5'h1;
            end else pk_flush = 1'b1;
            if (pk_bv) begin
               frm_next[3 + 3'(nbyte_reg[0])] = pk_byte;
               nbyte_next = nbyte_reg + 16'h1;
            end
            if (pk_flush && !pk_bv && pk_cnt_reg != 5'h0 &&
                nbyte_reg == 16'((frm_reg[5] + 8'h07) >> 3)) begin
               frm_next[2] = 8'(nbyte_reg);
               frm_next[5] = 8'h00;
               idx_next = 3'h0;
               st_next = ST_SEND;
            end
            if (frm_reg[5] == 8'h00 || frm_reg[5] > 8'h10) begin
               frm_next[1] = frm_reg[1] | mbre_pkg::EXC_FLAG;
               frm_next[2] = mbre_pkg::ERR_ILL_DATA;
               idx_next = 3'h0;
               st_next = ST_SEND;
            end
         end
         default: st_next = ST_IDLE;
      endcase
      if (st_reg == ST_RECV && st_next == ST_SANS) nbyte_next = 16'h0;
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= ST_IDLE;
         exec_reg <= 1'b0;
         for (int k = 0; k < 6; k++) frm_reg[k] <= 8'h00;
         idx_reg <= 3'h0;
         tmr_reg <= 32'h0;
         stat_reg <= 16'h0000;
         nbyte_reg <= 16'h0000;
         rxi_reg <= 4'h0;
         exc_reg <= 1'b0;
         ch_reg <= 2'h0;
         db_reg <= 4'h0;
         tv_reg <= 1'b0;
         te_reg <= 1'b0;
         tb_reg <= 8'h00;
         rv_reg <= 1'b0;
         rb_reg <= 8'h00;
         pk_cnt_reg <= 5'h0;
         sa_reg <= 8'h00;
      end else begin
         st_reg <= st_next;
         exec_reg <= exec_next;
         for (int k = 0; k < 6; k++) frm_reg[k] <= frm_next[k];
         idx_reg <= idx_next;
         tmr_reg <= tmr_next;
         stat_reg <= stat_next;
         nbyte_reg <= nbyte_next;
         rxi_reg <= rxi_next;
         exc_reg <= exc_next;
         ch_reg <= ch_next;
         db_reg <= db_next;
         tv_reg <= tv_next;
         te_reg <= te_next;
         tb_reg <= tb_next;
         rv_reg <= rv_next;
         rb_reg <= rb_next;
         pk_cnt_reg <= pk_cnt_next;
         sa_reg <= sa_next;
      end
   end

   assign tx_vld_out = tv_reg;
   assign tx_byte_out = tb_reg;
   assign tx_end_out = te_reg;
   assign channel_out = ch_reg;
   assign data_bits_out = db_reg;
   assign status_word_operand_out = stat_reg;
   assign rd_vld_out = rv_reg;
   assign rd_byte_out = rb_reg;

   ////////////////////////////////////////////////////////////////////
   done_one_scan_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      stat_reg[mbre_pkg::DONE_BIT] |=> !stat_reg[mbre_pkg::DONE_BIT])
      else $error("done flag longer than one scan");
   err_one_scan_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      stat_reg[mbre_pkg::ERR_BIT] |=> !stat_reg[mbre_pkg::ERR_BIT])
      else $error("error flag longer than one scan");
   flags_apart_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      !(stat_reg[mbre_pkg::DONE_BIT] && stat_reg[mbre_pkg::ERR_BIT]))
      else $error("done and error together");
   sequence own_req_s;
      st_reg == ST_IDLE && master_mode_in && rise && params_ok_in && tgt_st == own_station_in;
   endsequence
   own_station_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      own_req_s |=> stat_reg[15:8] == mbre_pkg::ERR_STATION && st_reg == ST_IDLE)
      else $error("own station not refused");
   zero_count_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      (st_reg == ST_IDLE && master_mode_in && rise && params_ok_in &&
       tgt_st != own_station_in && count_in == 16'h0000) |=> stat_reg[15:8] == mbre_pkg::ERR_NUMBER
      ##1 !tx_vld_out) else $error("zero count sent");
   bad_param_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      (st_reg == ST_IDLE && master_mode_in && rise && !params_ok_in) |=>
      stat_reg[15:8] == mbre_pkg::ERR_PARAM) else $error("parameter error missing");
   legacy_ch_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      legacy_form_in |=> channel_out == mbre_pkg::CH_LEGACY)
      else $error("legacy form not on channel 0");
   launch_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      (st_reg == ST_IDLE && master_mode_in && rise && params_ok_in &&
       tgt_st != own_station_in && count_in != 16'h0000 &&
       bytes_req <= 16'(mbre_pkg::MAX_BYTES)) |=> st_reg == ST_SEND)
      else $error("request not launched");
   ack_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      (st_reg == ST_HOLD) |-> !tx_vld_out) else $error("request reissued during hold");
   bits_mode_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      rtu_mode_in ##1 rtu_mode_in |-> data_bits_out == mbre_pkg::DBITS_RTU)
      else $error("rtu data bits wrong");
endmodule
`default_nettype wire

/* File: rtl/mbre_pkg.sv */
// Purpose: constants shared by the serial request engine
// Assumes: one clock at 100 MHz, active-low asynchronous reset
// Notes: status word layout and error codes live here
package mbre_pkg;
   localparam int CLK_MHZ = 100;
   localparam int TIMEOUT_MS = 500;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int ACK_WAIT_MS = 500;
   localparam int ACK_WAIT_CYC = ACK_WAIT_MS * 1000 * CLK_MHZ;
   localparam int DONE_BIT = 0;
   localparam int ERR_BIT = 1;
   localparam int CODE_LSB = 8;
   localparam int MAX_BYTES = 256;
   localparam logic [4:0] MAX_STATION = 5'h1F;
   localparam logic [4:0] BCAST_STATION = 5'h00;
   localparam logic [7:0] FN_READ_COILS = 8'h01;
   localparam logic [7:0] FN_READ_INPUTS = 8'h02;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] ERR_ILL_FUNC = 8'h01;
   localparam logic [7:0] ERR_ILL_ADDR = 8'h02;
   localparam logic [7:0] ERR_ILL_DATA = 8'h03;
   localparam logic [7:0] ERR_DEV_FAIL = 8'h04;
   localparam logic [7:0] ERR_ACK = 8'h05;
   localparam logic [7:0] ERR_BUSY = 8'h06;
   localparam logic [7:0] ERR_TIMEOUT = 8'h07;
   localparam logic [7:0] ERR_NUMBER = 8'h08;
   localparam logic [7:0] ERR_PARAM = 8'h09;
   localparam logic [7:0] ERR_STATION = 8'h0A;
   localparam logic [3:0] DBITS_ASCII = 4'h7;
   localparam logic [3:0] DBITS_RTU = 4'h8;
   localparam logic [1:0] CH_LEGACY = 2'h0;
endpackage

/* File: rtl/mbre_bit_packer.sv */
// Purpose: packs one coil/input bit at a time into bytes
// Assumes: bits arrive lowest item first
// Notes: a flush pads the partial byte with zeros
`timescale 1ns/1ps
`default_nettype none
module mbre_bit_packer (
   input wire logic ref_clk_in,   // clock
   input wire logic nrst_in,      // async reset, active low
   input wire logic clr_in,       // start a new byte stream
   input wire logic bit_vld_in,   // one data bit present
   input wire logic bit_in,       // the data bit
   input wire logic flush_in,     // emit partial byte
   output logic byte_vld_out,     // byte complete pulse
   output logic [7:0] byte_out    // packed byte
);
   logic [7:0] acc_reg, acc_next;
   logic [2:0] pos_reg, pos_next;
   logic vld_reg, vld_next;
   logic [7:0] out_reg, out_next;

   always_comb begin
      acc_next = acc_reg;
      pos_next = pos_reg;
      vld_next = 1'b0;
      out_next = out_reg;
      if (clr_in) begin
         acc_next = 8'h00;
         pos_next = 3'h0;
      end else if (bit_vld_in) begin
         acc_next = acc_reg | (8'({7'h00, bit_in}) << pos_reg);
         pos_next = pos_reg + 3'h1;
         if (pos_reg == 3'h7) begin
            vld_next = 1'b1;
            out_next = acc_reg | (8'({7'h00, bit_in}) << pos_reg);
            acc_next = 8'h00;
         end
      end else if (flush_in && pos_reg != 3'h0) begin
         vld_next = 1'b1;
         out_next = acc_reg;
         acc_next = 8'h00;
         pos_next = 3'h0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         acc_reg <= 8'h00;
         pos_reg <= 3'h0;
         vld_reg <= 1'b0;
         out_reg <= 8'h00;
      end else begin
         acc_reg <= acc_next;
         pos_reg <= pos_next;
         vld_reg <= vld_next;
         out_reg <= out_next;
      end
   end

   assign byte_vld_out = vld_reg;
   assign byte_out = out_reg;

   zero_pad_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
      (flush_in && !bit_vld_in && !clr_in && pos_reg != 3'h0) |=>
      (byte_vld_out && (byte_out >> $past(pos_reg)) == 8'h00))
      else $error("partial byte not zero padded");
endmodule
`default_nettype wire

/* File: verification/mbre_remote_station.sv */
// Purpose: remote station model that answers the engine's requests
// Assumes: bytes go out every second cycle; the frame end comes after the last byte
// Notes: the bench chooses the reply kind; silent mode forces a timeout
`timescale 1ns/1ps
`default_nettype none
module mbre_remote_station (
   input wire logic ref_clk_in,       // clock
   input wire logic tx_vld_in,        // engine byte valid
   input wire logic [7:0] tx_byte_in, // engine byte
   input wire logic tx_end_in,        // engine frame end
   input wire logic [1:0] mode_in,    // 0 silent, 1 data, 2 exception
   input wire logic [7:0] code_in,    // exception code
   input wire logic slow_in,          // late reply, stalled transmitter
   output logic rx_vld_out,           // byte to engine valid
   output logic [7:0] rx_byte_out,    // byte to engine
   output logic rx_end_out,           // frame end to engine
   output logic tx_rdy_out            // ready for engine byte
);
   logic [7:0] txq[$];
   logic [7:0] fr[$];
   logic stall_reg = 1'b0;
   assign tx_rdy_out = !slow_in || stall_reg;
   initial begin
      rx_vld_out = 1'b0;
      rx_byte_out = 8'h5A;
      rx_end_out = 1'b0;
   end
   always @(posedge ref_clk_in) begin
      stall_reg <= !stall_reg;
      if (tx_vld_in)
         txq.push_back(tx_byte_in);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // between bytes the line shows the inverse of the last byte, never a stale copy
   task automatic send;
      foreach (fr[i]) begin
         @(posedge ref_clk_in);
         rx_vld_out <= 1'b1;
         rx_byte_out <= fr[i];
         @(posedge ref_clk_in);
         rx_vld_out <= 1'b0;
         rx_byte_out <= ~fr[i];
      end
      @(posedge ref_clk_in);
      rx_end_out <= 1'b1;
      @(posedge ref_clk_in);
      rx_end_out <= 1'b0;
   endtask
   always begin
      @(posedge ref_clk_in);
      if (tx_vld_in && tx_end_in && mode_in != 2'h0) begin
         repeat (slow_in ? 40 : 3) @(posedge ref_clk_in);
         if (mode_in == 2'h1)
            fr = '{txq[$-5], txq[$-4], 8'h02, 8'hCD, 8'hB2};
         else
            fr = '{txq[$-5], txq[$-4] | 8'h80, code_in};
         send();
      end
   end
endmodule
`default_nettype wire

/* File: verification/mbre_engine_tb.sv */
// Purpose: self-checking bench for the serial request engine
// Assumes: shortened timeout and acknowledge hold of 200 cycles
// Notes: the remote model holds every byte that the engine sent
`timescale 1ns/1ps
`default_nettype none
module mbre_engine_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic master = 1'b1;
   logic rtu = 1'b1;
   logic ok = 1'b1;
   logic legacy = 1'b0;
   logic [1:0] chsel = 2'h2;
   logic exec = 1'b0;
   logic [15:0] sfo = 16'h0000;
   logic [15:0] sao = 16'h0000;
   logic [15:0] cnt = 16'h0000;
   logic [1:0] mode = 2'h1;
   logic [7:0] code = 8'h00;
   logic slow = 1'b0;
   logic rx_vld, rx_end, tx_rdy, tx_vld, tx_end, rd_vld;
   logic [7:0] rx_byte, tx_byte, rd_byte;
   logic [1:0] ch_out;
   logic [3:0] dbits;
   logic [15:0] status, stat;
   logic [7:0] rdq[$];
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int ticks = 0;
   always #5 clk = ~clk;
   mbre_engine #(.TIMEOUT_CYC(200), .ACK_WAIT_CYC(200)) uut (.ref_clk_in(clk), .nrst_in(nrst),
      .master_mode_in(master), .rtu_mode_in(rtu), .params_ok_in(ok), .legacy_form_in(legacy),
      .channel_select_in(chsel), .own_station_in(5'h05), .exec_in(exec),
      .station_function_operand_in(sfo), .start_address_operand_in(sao), .count_in(cnt),
      .rx_vld_in(rx_vld), .rx_byte_in(rx_byte), .rx_end_in(rx_end), .tx_rdy_in(tx_rdy),
      .local_bits_in(16'hDBAC), .tx_vld_out(tx_vld), .tx_byte_out(tx_byte), .tx_end_out(tx_end),
      .channel_out(ch_out), .data_bits_out(dbits), .status_word_operand_out(status),
      .rd_vld_out(rd_vld), .rd_byte_out(rd_byte));
   mbre_remote_station p (.ref_clk_in(clk), .tx_vld_in(tx_vld), .tx_byte_in(tx_byte),
      .tx_end_in(tx_end), .mode_in(mode), .code_in(code), .slow_in(slow), .rx_vld_out(rx_vld),
      .rx_byte_out(rx_byte), .rx_end_out(rx_end), .tx_rdy_out(tx_rdy));
   always @(posedge clk) begin
      ticks++;
      if (rd_vld)
         rdq.push_back(rd_byte);
      if (ticks == 20000) begin
         n_errors++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic [7:0] got, input logic [7:0] exp);
      chk({8'h00, got}, {8'h00, exp});
   endtask
   // status flags last one cycle, so every cycle is looked at
   task automatic wait_stat;
      stat = 16'h0000;
      cyc = 0;
      while (stat === 16'h0000 && cyc < 2000) begin
         @(posedge clk);
         #1;
         stat = status;
         cyc++;
      end
   endtask
   task automatic req(input logic [4:0] st, input logic [7:0] fn, input logic [15:0] n);
      @(posedge clk);
      sfo <= {3'h0, st, fn};
      sao <= 16'd20;
      cnt <= n;
      exec <= 1'b1;
      wait_stat();
      @(posedge clk);
      exec <= 1'b0;
   endtask
   task automatic refuse(input logic [4:0] st, input logic [7:0] fn, input logic [15:0] n,
                         input logic okv, input logic [7:0] e);
      int n0;
      n0 = p.txq.size();
      @(posedge clk);
      ok <= okv;
      req(st, fn, n);
      chk(stat, {e, 8'h02});
      chk(16'(p.txq.size()), 16'(n0));
   endtask
   task automatic t_master;
      logic [7:0] e[6] = '{8'h11, 8'h01, 8'h00, 8'h13, 8'h00, 8'h25};
      int n0;
      n0 = p.txq.size();
      @(posedge clk);
      slow <= 1'b1;
      req(5'h11, 8'h01, 16'd37);
      chk(stat, 16'h0001);
      foreach (e[i]) chkb(p.txq[n0 + i], e[i]);
      chkb(rdq[0], 8'hCD);
      chkb(rdq[1], 8'hB2);
      slow <= 1'b0;
      $display("test master request done");
   endtask
   task automatic t_errors;
      int n0;
      for (int c = 1; c <= 6; c++) begin
         @(posedge clk);
         mode <= 2'h2;
         code <= 8'(c);
         req(5'h11, 8'h02, 16'd22);
         chk(stat, {8'(c), 8'h02});
         if (c == 5) begin
            n0 = p.txq.size();
            @(posedge clk);
            exec <= 1'b1;
            repeat (150) @(posedge clk);
            chk(16'(p.txq.size()), 16'(n0));
            exec <= 1'b0;
            repeat (100) @(posedge clk);
         end
      end
      mode <= 2'h0;
      req(5'h11, 8'h01, 16'd8);
      chk(stat, 16'h0702);
      chk(16'(cyc > 200), 16'h0001);
      mode <= 2'h1;
      refuse(5'h05, 8'h01, 16'd8, 1'b0, 8'h09);
      refuse(5'h05, 8'h01, 16'd8, 1'b1, 8'h0A);
      refuse(5'h11, 8'h01, 16'd0, 1'b1, 8'h08);
      refuse(5'h11, 8'h01, 16'd2049, 1'b1, 8'h08);
      refuse(5'h11, 8'h03, 16'd129, 1'b1, 8'h08);
      $display("test error codes done");
   endtask
   task automatic t_cfg;
      @(posedge clk);
      legacy <= 1'b1;
      chsel <= 2'h3;
      rtu <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({10'h000, ch_out, dbits}, 16'h0007);
      @(posedge clk);
      legacy <= 1'b0;
      rtu <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({10'h000, ch_out, dbits}, 16'h0038);
      $display("test channel and framing done");
   endtask
   task automatic t_slave(input logic [7:0] fn);
      logic [7:0] e[6] = '{8'h05, fn, 8'h02, 8'hAC, 8'h0B, 8'h00};
      int n0;
      @(posedge clk);
      master <= 1'b0;
      mode <= 2'h0;
      n0 = p.txq.size();
      p.fr = '{8'h05, fn, 8'h00, 8'h00, 8'h00, 8'h0C};
      p.send();
      wait_stat();
      chk(stat, 16'h0001);
      repeat (20) @(posedge clk);
      foreach (e[i]) chkb(p.txq[n0 + i], e[i]);
      $display("test slave answer done");
   endtask
   task automatic final_report;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_master();
      t_errors();
      t_cfg();
      t_slave(8'h01);
      t_slave(8'h02);
      final_report();
   end
endmodule
`default_nettype wire
